/* inc/brap_pkg.sv */
// Package for the buffer random access port: offsets, resets, carriers
package brap_pkg;

  // ==========================================================================
  // Register offsets on the 8-bit direct register bus
  localparam logic [7:0] ADDR_RX_BUFFER_BYTE_PORT = 8'h02;
  localparam logic [7:0] ADDR_TX_BUFFER_BYTE_PORT = 8'h04;
  localparam logic [7:0] ADDR_BUFFER_POINTER_HIGH = 8'h08;
  localparam logic [7:0] ADDR_BUFFER_POINTER_LOW  = 8'h09;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BUFFER_POINTER_HIGH = 8'h00;
  localparam logic [7:0] RST_BUFFER_POINTER_LOW  = 8'h00;
  localparam logic [7:0] RST_READ_DATA           = 8'h00;

  // ==========================================================================
  // Buffer sizes in bytes
  localparam int TX_BUFFER_BYTES = 2048;
  localparam int RX_BUFFER_BYTES = 4096;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } brap_pointer_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brap_host_req_s;

endpackage

/* src/brap_top.sv */
// Buffer random access port with its transmit and receive byte buffers
`timescale 1ns/1ps

// What this block does
// R1 - Pointer high register holds address bits fifteen-eight
// R2 - Pointer low register holds address bits seven-zero
// R3 - Transmit data read returns addressed transmit byte
// R4 - Transmit data write stores addressed transmit byte
// R5 - Receive data read returns addressed receive byte
// R6 - Receive data write stores addressed receive byte
// R7 - Pointer high decoded at address 0x08
// R8 - Pointer low decoded at address 0x09
// R9 - Own pointer, independent of sequential interfaces
// R10 - Shared pointer; data register selects buffer
// R11 - Host loads pointer before data access
// R12 - Data accesses leave pointer unchanged
module brap_top
  import brap_pkg::*;
#(
  parameter int TX_DEPTH = TX_BUFFER_BYTES,
  parameter int RX_DEPTH = RX_BUFFER_BYTES
)
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_SYS_RST,
  // Host register bus, one access per strobe cycle
  input  wire logic       I_RD,
  input  wire logic       I_WR,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  // Read answer, one cycle after the read strobe
  output logic      [7:0] O_RDATA,
  output logic            O_RVALID,
  // Current buffer pointer
  output logic     [15:0] O_POINTER
);

  localparam int TXW = $clog2(TX_DEPTH);
  localparam int RXW = $clog2(RX_DEPTH);

  // ==========================================================================
  // State
  typedef struct packed {
    brap_pointer_s ptr;
    logic [7:0]    rdata;
    logic          rvalid;
  } brap_state_s;

  brap_state_s    st_r;
  brap_state_s    st_nxt;
  brap_host_req_s req;
  logic [7:0]     tx_mem [TX_DEPTH];
  logic [7:0]     rx_mem [RX_DEPTH];
  logic [15:0]    ptr_word;
  logic [TXW-1:0] tx_idx;
  logic [RXW-1:0] rx_idx;
  logic           tx_hit;
  logic           rx_hit;

  // Decoding shared by the read path and the buffer write enables
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign req.rd    = I_RD;
  assign req.wr    = I_WR;
  assign req.addr  = I_ADDR;
  assign req.wdata = I_WDATA;

  // One pointer serves both buffers; the data register picks which [R10]
  assign ptr_word = {st_r.ptr.high, st_r.ptr.low}; // [R1] [R2]
  // Out-of-range pointer bits are dropped; each index wraps inside its own buffer
  assign tx_idx   = ptr_word[TXW-1:0];
  assign rx_idx   = ptr_word[RXW-1:0];
  assign tx_hit   = hit(req.addr, ADDR_TX_BUFFER_BYTE_PORT);
  assign rx_hit   = hit(req.addr, ADDR_RX_BUFFER_BYTE_PORT);

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = req.rd;
    if (req.wr)
    begin
      // Only the pointer offsets touch the pointer [R12] [R9]
      if (hit(req.addr, ADDR_BUFFER_POINTER_HIGH))
      begin
        st_nxt.ptr.high = req.wdata; // [R7] [R1]
      end
      if (hit(req.addr, ADDR_BUFFER_POINTER_LOW))
      begin
        st_nxt.ptr.low = req.wdata; // [R8] [R2]
      end
    end
    if (req.rd)
    begin
      case (1'b1)
        hit(req.addr, ADDR_BUFFER_POINTER_HIGH):
          st_nxt.rdata = st_r.ptr.high; // [R7]
        hit(req.addr, ADDR_BUFFER_POINTER_LOW):
          st_nxt.rdata = st_r.ptr.low; // [R8]
        tx_hit:
          st_nxt.rdata = tx_mem[tx_idx]; // [R3]
        rx_hit:
          st_nxt.rdata = rx_mem[rx_idx]; // [R5]
        default:
          // Other offsets belong to other blocks and read as zero here
          st_nxt.rdata = RST_READ_DATA;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      st_r.ptr.high <= RST_BUFFER_POINTER_HIGH;
      st_r.ptr.low  <= RST_BUFFER_POINTER_LOW;
      st_r.rdata    <= RST_READ_DATA;
      st_r.rvalid   <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Buffers; contents are not reset, as in a real RAM
  always_ff @(posedge I_CLK)
  begin
    if (req.wr && tx_hit)
    begin
      tx_mem[tx_idx] <= req.wdata; // [R4]
    end
    if (req.wr && rx_hit)
    begin
      rx_mem[rx_idx] <= req.wdata; // [R6]
    end
  end

  assign O_RDATA   = st_r.rdata;
  assign O_RVALID  = st_r.rvalid;
  assign O_POINTER = ptr_word;

  // ==========================================================================
  // Checks
  chk_ptr_high_wr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && I_ADDR == ADDR_BUFFER_POINTER_HIGH |=> O_POINTER[15:8] ==
    $past(I_WDATA)) else $error("pointer high write lost"); // [R1]
  chk_ptr_low_wr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && I_ADDR == ADDR_BUFFER_POINTER_LOW |=> O_POINTER[7:0] ==
    $past(I_WDATA)) else $error("pointer low write lost"); // [R2]
  chk_tx_roundtrip: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && !I_RD && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT ##1
    I_RD && !I_WR && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT |=>
    O_RVALID && O_RDATA == $past(I_WDATA, 2))
    else $error("transmit byte not returned"); // [R3] [R4]
  chk_rx_roundtrip: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && !I_RD && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT ##1
    I_RD && !I_WR && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT |=>
    O_RVALID && O_RDATA == $past(I_WDATA, 2))
    else $error("receive byte not returned"); // [R5] [R6]
  chk_high_readback: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && I_ADDR == ADDR_BUFFER_POINTER_HIGH |=>
    O_RDATA == $past(O_POINTER[15:8]))
    else $error("pointer high readback wrong"); // [R7]
  chk_low_readback: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD && I_ADDR == ADDR_BUFFER_POINTER_LOW |=>
    O_RDATA == $past(O_POINTER[7:0]))
    else $error("pointer low readback wrong"); // [R8]
  chk_ptr_stable: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !(I_WR && (I_ADDR == ADDR_BUFFER_POINTER_HIGH ||
    I_ADDR == ADDR_BUFFER_POINTER_LOW)) |=> $stable(O_POINTER))
    else $error("pointer moved without write"); // [R12] [R9]
  chk_buf_separate: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_WR && !I_RD && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT ##1
    I_WR && !I_RD && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT &&
    I_WDATA != $past(I_WDATA) ##1
    I_RD && !I_WR && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT |=>
    O_RDATA == $past(I_WDATA, 3))
    else $error("buffers not separate"); // [R10]
  chk_read_answer: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_RD |=> O_RVALID ##1 (O_RVALID == $past(I_RD)))
    else $error("read answer timing wrong"); // [R3] [R5]

  // ==========================================================================
  // Read answer shape and reset behaviour
  // Every read strobe yields an answer in the next cycle
  chk_rvalid_pulse: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_RD |=> O_RVALID)
    else $error("read answer missing"); // [R3] [R5]

  // No answer may appear without a read behind it
  chk_rvalid_idle: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    !I_RD |=> !O_RVALID)
    else $error("read answer without read"); // [R3] [R5]

  // Read data is held between reads so a slow host can still take it
  chk_rdata_hold: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    !I_RD |=> $stable(O_RDATA))
    else $error("read data moved without read"); // [R3] [R5]

  // Offsets owned by other blocks answer with zero here
  chk_unmapped_read: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_RD && I_ADDR != ADDR_RX_BUFFER_BYTE_PORT &&
    I_ADDR != ADDR_TX_BUFFER_BYTE_PORT &&
    I_ADDR != ADDR_BUFFER_POINTER_HIGH &&
    I_ADDR != ADDR_BUFFER_POINTER_LOW |=> O_RDATA == RST_READ_DATA)
    else $error("unmapped read not zero"); // [R7] [R8]

  // Reset clears the pointer at the very next edge
  chk_reset_ptr: assert property (@(posedge I_CLK)
    I_SYS_RST |=> O_POINTER == 16'h0000)
    else $error("pointer not cleared by reset"); // [R1] [R2]

  // Reset also drops any pending answer
  chk_reset_answer: assert property (@(posedge I_CLK)
    I_SYS_RST |=> !O_RVALID && O_RDATA == RST_READ_DATA)
    else $error("read answer not cleared by reset"); // [R3] [R5]

  // ==========================================================================
  // Pointer byte independence
  // Loading the high byte must not disturb the low byte
  chk_high_keeps_low: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && I_ADDR == ADDR_BUFFER_POINTER_HIGH |=>
    O_POINTER[7:0] == $past(O_POINTER[7:0]))
    else $error("high write moved low byte"); // [R1] [R2]

  // Loading the low byte must not disturb the high byte
  chk_low_keeps_high: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && I_ADDR == ADDR_BUFFER_POINTER_LOW |=>
    O_POINTER[15:8] == $past(O_POINTER[15:8]))
    else $error("low write moved high byte"); // [R1] [R2]

  // A freshly written high byte reads back on the next access
  chk_high_wr_rd: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && !I_RD && I_ADDR == ADDR_BUFFER_POINTER_HIGH ##1
    I_RD && !I_WR && I_ADDR == ADDR_BUFFER_POINTER_HIGH |=>
    O_RDATA == $past(I_WDATA, 2))
    else $error("pointer high write not read back"); // [R7]

  // A freshly written low byte reads back on the next access
  chk_low_wr_rd: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && !I_RD && I_ADDR == ADDR_BUFFER_POINTER_LOW ##1
    I_RD && !I_WR && I_ADDR == ADDR_BUFFER_POINTER_LOW |=>
    O_RDATA == $past(I_WDATA, 2))
    else $error("pointer low write not read back"); // [R8]

  // Read and write together: old value out, new value in
  chk_high_same_cyc: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && I_RD && I_ADDR == ADDR_BUFFER_POINTER_HIGH |=>
    O_RDATA == $past(O_POINTER[15:8]) &&
    O_POINTER[15:8] == $past(I_WDATA))
    else $error("pointer high read-write clash"); // [R7]

  // ==========================================================================
  // Pointer left alone by everything but its own offsets
  // Writes to any offset but the two pointer offsets leave the pointer alone
  chk_unmapped_write: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && I_ADDR != ADDR_BUFFER_POINTER_HIGH &&
    I_ADDR != ADDR_BUFFER_POINTER_LOW |=> $stable(O_POINTER))
    else $error("foreign write moved pointer"); // [R12] [R9]

  // Reads never move the pointer, so polling a byte is safe
  chk_read_keeps_ptr: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_RD && !I_WR |=> $stable(O_POINTER))
    else $error("read moved pointer"); // [R12]

  // Two transmit reads in a row see the same byte
  chk_tx_same_byte: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_RD && !I_WR && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT ##1
    I_RD && !I_WR && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT |=>
    $stable(O_RDATA))
    else $error("transmit reread differs"); // [R12] [R3]

  // Two receive reads in a row see the same byte
  chk_rx_same_byte: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_RD && !I_WR && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT ##1
    I_RD && !I_WR && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT |=>
    $stable(O_RDATA))
    else $error("receive reread differs"); // [R12] [R5]

  // A transmit write never lands in the receive buffer
  chk_rx_separate: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && !I_RD && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT ##1
    I_WR && !I_RD && I_ADDR == ADDR_TX_BUFFER_BYTE_PORT &&
    I_WDATA != $past(I_WDATA) ##1
    I_RD && !I_WR && I_ADDR == ADDR_RX_BUFFER_BYTE_PORT |=>
    O_RDATA == $past(I_WDATA, 3))
    else $error("receive buffer overwritten"); // [R10]

  // Data writes leave the pointer where the host put it
  chk_data_wr_ptr: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST)
    I_WR && (I_ADDR == ADDR_TX_BUFFER_BYTE_PORT ||
    I_ADDR == ADDR_RX_BUFFER_BYTE_PORT) |=> $stable(O_POINTER))
    else $error("data write moved pointer"); // [R12]

endmodule

/* sim/brap_host.sv */
// Host processor model on the 8-bit register bus
`timescale 1ns/1ps
module brap_host
(
  // Clock and answer
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // Request
  output logic            o_rd = 1'b0,
  output logic            o_wr = 1'b0,
  output logic      [7:0] o_addr = 8'h00,
  output logic      [7:0] o_wdata = 8'h00
);
  // ==========================================================================
  // One strobe cycle; a read waits a bounded time for its answer
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q, output logic ok);
    int n;
    q = 8'h00;
    ok = w;
    @(posedge i_clk);
    o_rd <= !w;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // Released lines flip so a stale value is never trusted
    o_addr <= ~a;
    o_wdata <= ~d;
    for (n = 0; n < 4 && !ok; n++)
    begin
      #1;
      if (i_rvalid === 1'b1)
      begin
        q = i_rdata;
        ok = 1'b1;
      end
      else
        @(posedge i_clk);
    end
  endtask
endmodule

/* sim/brap_top_bench.sv */
// Self-checking bench for the buffer random access port
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  fails++; $display("Error %0t: got %h exp %h", $time, got, exp); end end
module brap_top_bench;
  import brap_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} brap_row_s;
  localparam brap_row_s ROWS [15] = '{
    '{1, 8'h08, 8'h00}, '{1, 8'h09, 8'h05}, '{1, 8'h04, 8'ha5},
    '{1, 8'h02, 8'h5a}, '{0, 8'h04, 8'ha5}, '{0, 8'h02, 8'h5a},
    '{0, 8'h09, 8'h05}, '{1, 8'h09, 8'h06}, '{1, 8'h04, 8'hc3},
    '{0, 8'h04, 8'hc3}, '{0, 8'h04, 8'hc3}, '{1, 8'h09, 8'h05},
    '{0, 8'h04, 8'ha5}, '{1, 8'h08, 8'h7e}, '{0, 8'h08, 8'h7e}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd;
  logic        wr;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [15:0] pointer;
  logic [7:0]  q;
  int          fails = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  brap_host u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

  // Small buffers keep the index wrap visible in a short run
  brap_top #(.TX_DEPTH(16), .RX_DEPTH(16)) u_brap_top (.I_CLK(clk),
    .I_SYS_RST(rst), .I_RD(rd), .I_WR(wr), .I_ADDR(addr), .I_WDATA(wdata),
    .O_RDATA(rdata), .O_RVALID(rvalid), .O_POINTER(pointer));

  task automatic end_sim();
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic op(input logic w, input logic [7:0] a, d);
    logic ok;
    u_host.access(w, a, d, q, ok);
    if (!ok)
    begin
      fails++;
      end_sim();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHECK(pointer, 16'h0000)
    op(0, ADDR_BUFFER_POINTER_LOW, 8'h00);
    `CHECK(q, RST_BUFFER_POINTER_LOW)
    foreach (ROWS[i])
    begin
      op(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) `CHECK(q, ROWS[i].d)
    end
    `CHECK(pointer, 16'h7e05)
    // Unmapped place: write ignored, read gives zero, pointer untouched
    op(1, 8'h03, 8'hff);
    op(0, 8'h03, 8'h00);
    `CHECK(q, 8'h00)
    op(1, 8'h02, 8'h11);
    `CHECK(pointer, 16'h7e05)
    op(0, 8'h02, 8'h00);
    `CHECK(q, 8'h11)
    op(0, 8'h04, 8'h00);
    `CHECK(q, 8'ha5)
    // Second reset in mid-run clears the pointer
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHECK(pointer, 16'h0000)
    end_sim();
  end
endmodule
